// *** hdl/adcs_defines.svh ***
// constants for the converter channel select and encoder phase block
// assumes inclusion by the design module only
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH
// frame field positions
`define ADCS_IN_START_BIT 1
`define ADCS_IN_SEL_LO 2
`define ADCS_OUT_DONE1_BIT 0
`define ADCS_OUT_DONE2_BIT 1
`define ADCS_OUT_PHA_BIT 2
`define ADCS_OUT_PHB_BIT 3
`define ADCS_OUT_SRC_LO 4
`define ADCS_FRAME_BITS 16
// sample and hold, in serial clock periods
`define ADCS_SH_SCLKS 15
// conversion length, in serial clock periods per result
`define ADCS_CONV_SCLKS 8
// register offsets
`define ADCS_REG_STATUS 4'h0
`define ADCS_REG_MASK 4'h1
`define ADCS_REG_GAIN 4'h2
`define ADCS_REG_STATE 4'h3
// interrupt status bits
`define ADCS_IRQ_DONE1 0
`define ADCS_IRQ_DONE2 1
`define ADCS_IRQ_IGNORED 2
`endif

// *** hdl/adcs_pkg.sv ***
// types for the converter channel select and encoder phase block
// assumes the defines header is on the include path
package adcs_pkg;
    // channel codes, same encoding as the selection field
    typedef enum logic [2:0] {
        ADCS_CH_GP0 = 3'h0,
        ADCS_CH_GP1 = 3'h1,
        ADCS_CH_ENC_B_INV_PAIR = 3'h2,
        ADCS_CH_AUTO = 3'h3,
        ADCS_CH_A_B_PAIR = 3'h4,
        ADCS_CH_A_AINV_PAIR = 3'h5,
        ADCS_CH_B_BINV_PAIR = 3'h6,
        ADCS_CH_DIRECT_PAIR = 3'h7
    } adcs_sel_t;
    // analog mux inputs
    typedef enum logic [2:0] {
        ADCS_MUX_GP0 = 3'h0,
        ADCS_MUX_GP1 = 3'h1,
        ADCS_MUX_DIR2 = 3'h2,
        ADCS_MUX_DIR3 = 3'h3,
        ADCS_MUX_ENC_A = 3'h4,
        ADCS_MUX_ENC_B = 3'h5,
        ADCS_MUX_ENC_AINV = 3'h6,
        ADCS_MUX_ENC_BINV = 3'h7
    } adcs_mux_t;
    typedef enum logic [3:0] {
        ADCS_ST_IDLE = 4'b0001,
        ADCS_ST_SAMPLE = 4'b0010,
        ADCS_ST_CONV1 = 4'b0100,
        ADCS_ST_CONV2 = 4'b1000
    } adcs_state_t;
    // returned frame fields
    typedef struct packed {
        logic [2:0] source;
        logic phase_b;
        logic phase_a;
        logic done2;
        logic done1;
    } adcs_status_t;
    // analog front end control
    typedef struct packed {
        adcs_mux_t mux;
        logic sample;
        logic convert;
    } adcs_afe_t;
endpackage

// *** hdl/adcs_core.sv ***
// converter sequencing, channel select and encoder phase capture
// assumes serial frames arrive as pin levels synchronised here; one clock domain
//
// The implementer's own choices: the plain strobed port and the register offsets.
`include "adcs_defines.svh"
module adcs_core
    import adcs_pkg::*;
#(
    parameter int GAIN_BITS = 4
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic ce_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    // encoder filter outputs
    input wire logic enc_phase_a_i,
    input wire logic enc_phase_b_i,
    // converter result
    input wire logic [7:0] conv_data_i,
    // analog front end control
    output adcs_afe_t afe_o,
    output logic [7:0] result_o,
    output logic [GAIN_BITS-1:0] gain_o,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // interrupt
    output logic irq_o
);
    if (GAIN_BITS < 1 || GAIN_BITS > 16) begin : g_gain_check
        $error("gain width unsupported");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic sclk_d;
    always_ff @(posedge mclk_i) begin
        sync1 <= {enc_phase_b_i, enc_phase_a_i, mosi_i, ce_n_i, sclk_i};
        sync2 <= sync1;
        sclk_d <= rst_i ? 1'b0 : sync2[0];
    end
    wire sclk_s = sync2[0];
    wire ce_n_s = sync2[1];
    wire mosi_s = sync2[2];
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire shift_en = sclk_rise & ~ce_n_s;

    // ------------------------------------------------------------
    // frame shifters
    // ------------------------------------------------------------
    logic [15:0] in_shift;
    logic [15:0] out_shift;
    logic ce_n_d;
    logic [1:0] phase;
    wire frame_end = ce_n_s & ~ce_n_d;
    wire frame_start = ~ce_n_s & ce_n_d;
    wire start_req = frame_end & in_shift[`ADCS_IN_START_BIT];
    wire [2:0] frame_sel = in_shift[`ADCS_IN_SEL_LO +: 3];
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            in_shift <= 16'h0000;
            ce_n_d <= 1'b1;
            phase <= 2'b00;
        end else begin
            ce_n_d <= ce_n_s;
            if (shift_en) begin
                in_shift <= {in_shift[14:0], mosi_s};
            end
            if (sclk_rise) begin
                phase <= {sync2[4], sync2[3]};
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer, paced by serial clock edges
    // ------------------------------------------------------------
    adcs_state_t state;
    adcs_state_t next_state;
    adcs_sel_t sel;
    logic [4:0] edge_cnt;
    logic done1_pend;
    logic done2_pend;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [2:0] src;
    wire busy = (state != ADCS_ST_IDLE);
    wire is_pair = sel[2];
    wire sh_done = (edge_cnt == 5'(`ADCS_SH_SCLKS - 1)) && sclk_rise;
    wire cv_done = (edge_cnt == 5'(`ADCS_CONV_SCLKS - 1)) && sclk_rise;
    always_comb begin
        next_state = state;
        case (state)
            ADCS_ST_IDLE: if (start_req) next_state = ADCS_ST_SAMPLE;
            ADCS_ST_SAMPLE: if (sh_done) next_state = ADCS_ST_CONV1;
            ADCS_ST_CONV1: if (cv_done) next_state = is_pair ? ADCS_ST_CONV2 : ADCS_ST_IDLE;
            ADCS_ST_CONV2: if (cv_done) next_state = ADCS_ST_IDLE;
            default: next_state = ADCS_ST_IDLE;
        endcase
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= ADCS_ST_IDLE;
            edge_cnt <= 5'h0;
            sel <= ADCS_CH_GP0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                edge_cnt <= 5'h0;
            end else if (sclk_rise && busy) begin
                edge_cnt <= edge_cnt + 5'h1;
            end
            if (start_req && !busy) begin
                sel <= adcs_sel_t'(frame_sel);
            end
        end
    end

    // ------------------------------------------------------------
    // mux selection
    // ------------------------------------------------------------
    adcs_mux_t mux_first;
    adcs_mux_t mux_second;
    always_comb begin
        mux_first = ADCS_MUX_GP0;
        mux_second = ADCS_MUX_GP0;
        case (sel)
            ADCS_CH_GP0: mux_first = ADCS_MUX_GP0;
            ADCS_CH_GP1: mux_first = ADCS_MUX_GP1;
            ADCS_CH_AUTO: mux_first = (phase[0] ^ phase[1]) ? ADCS_MUX_ENC_A
                                                         : ADCS_MUX_ENC_B;
            ADCS_CH_A_AINV_PAIR: begin
                mux_first = ADCS_MUX_ENC_A;
                mux_second = ADCS_MUX_ENC_AINV;
            end
            ADCS_CH_A_B_PAIR: begin
                mux_first = ADCS_MUX_ENC_A;
                mux_second = ADCS_MUX_ENC_B;
            end
            ADCS_CH_B_BINV_PAIR: begin
                mux_first = ADCS_MUX_ENC_B;
                mux_second = ADCS_MUX_ENC_BINV;
            end
            ADCS_CH_DIRECT_PAIR: begin
                mux_first = ADCS_MUX_DIR2;
                mux_second = ADCS_MUX_DIR3;
            end
            default: mux_first = ADCS_MUX_GP0;
        endcase
    end
    // one mux code at a time into the single converter
    assign afe_o.mux = (state == ADCS_ST_CONV2) ? mux_second : mux_first;
    assign afe_o.sample = (state == ADCS_ST_SAMPLE);
    assign afe_o.convert = (state == ADCS_ST_CONV1) || (state == ADCS_ST_CONV2);

    // ------------------------------------------------------------
    // results and done flags
    // ------------------------------------------------------------
    logic ignored_ev;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            res1 <= 8'h00;
            res2 <= 8'h00;
            src <= 3'h0;
            done1_pend <= 1'b0;
            done2_pend <= 1'b0;
            ignored_ev <= 1'b0;
        end else begin
            ignored_ev <= start_req && busy;
            if (state == ADCS_ST_CONV1 && cv_done) begin
                res1 <= conv_data_i;
                src <= sel;
                done1_pend <= 1'b1;
            end else if (frame_start && done1_pend) begin
                done1_pend <= 1'b0;
            end
            if (state == ADCS_ST_CONV2 && cv_done) begin
                res2 <= conv_data_i;
                done2_pend <= 1'b1;
            end else if (frame_start && done2_pend && !done1_pend) begin
                done2_pend <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // output frame, loaded at frame start and shifted on falling sclk
    // ------------------------------------------------------------
    adcs_status_t stat;
    assign stat.source = src;
    assign stat.phase_b = phase[1];
    assign stat.phase_a = phase[0];
    assign stat.done2 = done2_pend && !done1_pend;
    assign stat.done1 = done1_pend;
    wire [7:0] cur_res = stat.done2 ? res2 : res1;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            out_shift <= 16'h0000;
            result_o <= 8'h00;
        end else if (frame_start) begin
            out_shift <= {cur_res, 1'b0, stat};
            result_o <= cur_res;
        end else if (sclk_fall && !ce_n_s) begin
            out_shift <= {out_shift[14:0], 1'b0};
        end
    end
    assign miso_o = out_shift[15];

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [GAIN_BITS-1:0] gain;
    wire hit_stat = reg_wr_i && reg_addr_i == `ADCS_REG_STATUS;
    wire [2:0] irq_ev = {ignored_ev, state == ADCS_ST_CONV2 && cv_done,
                         state == ADCS_ST_CONV1 && cv_done};
    wire [2:0] clr = hit_stat ? reg_wdata_i[2:0] : 3'h0;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            gain <= '0;
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            irq_stat <= (irq_stat & ~clr) | irq_ev;
            if (reg_wr_i && reg_addr_i == `ADCS_REG_MASK) begin
                irq_mask <= reg_wdata_i[2:0];
            end
            if (reg_wr_i && reg_addr_i == `ADCS_REG_GAIN) begin
                gain <= reg_wdata_i[GAIN_BITS-1:0];
            end
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ADCS_REG_STATUS: reg_rdata_o <= {29'h0, irq_stat};
                    `ADCS_REG_MASK: reg_rdata_o <= {29'h0, irq_mask};
                    `ADCS_REG_GAIN: reg_rdata_o <= 32'(gain);
                    `ADCS_REG_STATE: reg_rdata_o <= {16'h0, res2, 1'b0, stat};
                    default: reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign gain_o = gain;
    assign irq_o = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_pair_start;
        state == ADCS_ST_SAMPLE && is_pair;
    endsequence
    a_busy_ignores_start: assert property (@(posedge mclk_i) disable iff (rst_i)
        start_req && busy |=> $stable(sel))
        else $error("selection changed while busy");
    a_idle_start_samples: assert property (@(posedge mclk_i) disable iff (rst_i)
        start_req && !busy |=> state == ADCS_ST_SAMPLE)
        else $error("start did not begin sampling");
    a_sel_frozen: assert property (@(posedge mclk_i) disable iff (rst_i)
        busy && $past(busy) |-> $stable(sel))
        else $error("selection moved during conversion");
    a_pair_two_conv: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ADCS_ST_CONV1 && cv_done && is_pair |=> state == ADCS_ST_CONV2)
        else $error("pair missed second conversion");
    a_single_one_conv: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ADCS_ST_CONV1 && cv_done && !is_pair |=> state == ADCS_ST_IDLE)
        else $error("single ran a second conversion");
    a_pair_sample_first: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_pair_start ##1 state == ADCS_ST_CONV1 |-> afe_o.mux == ((sel == ADCS_CH_DIRECT_PAIR) ?
            ADCS_MUX_DIR2 : (sel == ADCS_CH_B_BINV_PAIR) ? ADCS_MUX_ENC_B : ADCS_MUX_ENC_A))
        else $error("pair first input wrong");
    a_auto_select: assert property (@(posedge mclk_i) disable iff (rst_i)
        sel == ADCS_CH_AUTO && phase == 2'b00 |-> mux_first == ADCS_MUX_ENC_B)
        else $error("auto select picked wrong channel");
    a_phase_capture: assert property (@(posedge mclk_i) disable iff (rst_i)
        sclk_rise |=> phase == $past(sync2[4:3]))
        else $error("phase bits not latched");
    a_done_once: assert property (@(posedge mclk_i) disable iff (rst_i)
        frame_start && done1_pend |=> !done1_pend || $past(state == ADCS_ST_CONV1 && cv_done))
        else $error("done flag lasted past one frame");
    a_src_field: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ADCS_ST_CONV1 && cv_done |=> src == sel)
        else $error("source field mismatch");
    sequence s_sample_end;
        state == ADCS_ST_SAMPLE ##1 state != ADCS_ST_SAMPLE;
    endsequence
    a_sample_then_conv: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_sample_end |-> state == ADCS_ST_CONV1 && afe_o.convert)
        else $error("sampling not followed by first conversion");
    a_pair_second_input: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ADCS_ST_CONV2 |-> afe_o.mux == ((sel == ADCS_CH_A_B_PAIR) ? ADCS_MUX_ENC_B :
            (sel == ADCS_CH_A_AINV_PAIR) ? ADCS_MUX_ENC_AINV :
            (sel == ADCS_CH_B_BINV_PAIR) ? ADCS_MUX_ENC_BINV : ADCS_MUX_DIR3))
        else $error("pair second input wrong");
    a_single_gp_input: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ADCS_ST_CONV1 && sel == ADCS_CH_GP1 |-> afe_o.mux == ADCS_MUX_GP1)
        else $error("single conversion picked wrong input");
    a_auto_phase_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        sel == ADCS_CH_AUTO && state == ADCS_ST_CONV1 && phase[0] != phase[1]
            |-> afe_o.mux == ADCS_MUX_ENC_A)
        else $error("auto select missed channel a");
    a_count_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
        busy && state != ADCS_ST_SAMPLE |-> edge_cnt < 5'(`ADCS_CONV_SCLKS))
        else $error("conversion edge count overran");
    a_done1_loaded: assert property (@(posedge mclk_i) disable iff (rst_i)
        frame_start && done1_pend |=> out_shift[`ADCS_OUT_DONE1_BIT])
        else $error("first done flag not loaded into frame");
    a_phase_in_frame: assert property (@(posedge mclk_i) disable iff (rst_i)
        frame_start |=> out_shift[`ADCS_OUT_PHB_BIT:`ADCS_OUT_PHA_BIT] == $past(phase))
        else $error("phase bits not loaded into frame");
    a_gain_any_frame: assert property (@(posedge mclk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == `ADCS_REG_GAIN
            |=> gain_o == $past(reg_wdata_i[GAIN_BITS-1:0]))
        else $error("gain write not taken");
    a_done1_set_wins: assert property (@(posedge mclk_i) disable iff (rst_i)
        irq_ev[0] |=> irq_stat[0])
        else $error("first done status lost");
    a_done2_pending: assert property (@(posedge mclk_i) disable iff (rst_i)
        state == ADCS_ST_CONV2 && cv_done |=> done2_pend)
        else $error("second done flag not raised");
    a_ignore_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
        start_req && busy |=> ignored_ev)
        else $error("ignored start not flagged");
endmodule

// *** test/adcs_host_model.sv ***
// host model that drives serial frames into the block
// assumes a free-running mclk_i; frame timing is counted in mclk cycles
module adcs_host_model (
    // clock
    input wire logic mclk_i,
    // serial pins
    output logic sclk_o,
    output logic ce_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 6;
    initial begin
        sclk_o = 1'b0;
        ce_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one frame, msb first; select in bits 4..2, start in bit 1
    task automatic xfer(input logic [15:0] din, output logic [15:0] dout);
        ce_n_o <= 1'b0;
        repeat (8) @(posedge mclk_i);
        for (int i = 15; i >= 0; i--) begin
            mosi_o <= din[i];
            repeat (HALF) @(posedge mclk_i);
            dout[i] = miso_i;
            sclk_o <= 1'b1;
            repeat (HALF) @(posedge mclk_i);
            sclk_o <= 1'b0;
        end
        repeat (HALF) @(posedge mclk_i);
        // serial clock stays low between frames, data line flips when released
        ce_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule

// *** test/tb_adc_channel_select_encoder_phase.sv ***
// self-checking bench for the converter select and encoder phase block
// assumes adcs_host_model as the serial host and a 100 MHz mclk
module tb_adc_channel_select_encoder_phase
    import adcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, sclk, ce_n, mosi, miso, pha, phb, wr, rd, irq;
    logic prev_conv, bad_hold;
    logic [7:0] conv_data, result, salt;
    adcs_afe_t afe;
    logic [3:0] gain, addr;
    logic [31:0] wdata, rdata, r;
    logic [31:0] seed = 32'h0000_000f;
    logic [2:0] codes [12] = '{0, 1, 3, 3, 3, 3, 4, 5, 6, 7, 4, 7};
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    adcs_mux_t seen[$];

    adcs_core #(.GAIN_BITS(4)) u_dut (
        .mclk_i(mclk), .rst_i(rst), .sclk_i(sclk), .ce_n_i(ce_n), .mosi_i(mosi),
        .miso_o(miso), .enc_phase_a_i(pha), .enc_phase_b_i(phb),
        .conv_data_i(conv_data), .afe_o(afe), .result_o(result), .gain_o(gain),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .irq_o(irq)
    );
    adcs_host_model u_host (
        .mclk_i(mclk), .sclk_o(sclk), .ce_n_o(ce_n), .mosi_o(mosi), .miso_i(miso)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // converter stand-in and mux watcher
    always @(posedge mclk) begin
        conv_data <= salt ^ {5'h00, afe.mux};
        if (afe.convert && (!prev_conv || afe.mux !== seen[$]))
            seen.push_back(afe.mux);
        if (afe.sample && seen.size() != 0)
            bad_hold <= 1'b1;
        prev_conv <= afe.convert;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic adcs_mux_t exp_mux(logic [2:0] s, logic a, logic b, int k);
        case (s)
            3'h0: return ADCS_MUX_GP0;
            3'h1: return ADCS_MUX_GP1;
            3'h3: return (a ^ b) ? ADCS_MUX_ENC_A : ADCS_MUX_ENC_B;
            3'h4: return k ? ADCS_MUX_ENC_B : ADCS_MUX_ENC_A;
            3'h5: return k ? ADCS_MUX_ENC_AINV : ADCS_MUX_ENC_A;
            3'h6: return k ? ADCS_MUX_ENC_BINV : ADCS_MUX_ENC_B;
            default: return k ? ADCS_MUX_DIR3 : ADCS_MUX_DIR2;
        endcase
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    task automatic wr_reg(logic [3:0] a, logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        d = rdata;
    endtask

    task automatic run(logic [2:0] s, logic abuse, logic a, logic b);
        logic [15:0] o;
        logic [31:0] v;
        logic pair;
        int n1;
        int n2;
        pair = s[2];
        n1 = 0;
        n2 = 0;
        v = xs();
        salt <= v[7:0];
        pha <= a;
        phb <= b;
        @(posedge mclk);
        seen.delete();
        bad_hold = 1'b0;
        u_host.xfer({11'h000, s, 2'b10}, o);
        v = xs();
        wr_reg(4'h2, v);
        @(posedge mclk);
        chk("gain", 32'(v[3:0]), 32'(gain));
        for (int f = 0; f < 8; f++) begin
            v = xs();
            u_host.xfer((f == 0 && abuse) ? {v[15:5], ~s, 2'b10} : 16'h0000, o);
            chk("phase", 32'({b, a}), 32'(o[3:2]));
            chk("overlap", 0, 32'(o[1:0] == 2'b11));
            if (o[0] || o[1])
                chk("source", 32'(s), 32'(o[6:4]));
            if (o[0]) begin
                n1++;
                chk("res1", 32'(salt ^ {5'h00, exp_mux(s, a, b, 0)}), 32'(o[15:8]));
                chk("result_o1", 32'(salt ^ {5'h00, exp_mux(s, a, b, 0)}), 32'(result));
            end
            if (o[1]) begin
                n2++;
                chk("res2", 32'(salt ^ {5'h00, exp_mux(s, a, b, 1)}), 32'(o[15:8]));
                chk("result_o2", 32'(salt ^ {5'h00, exp_mux(s, a, b, 1)}), 32'(result));
            end
        end
        chk("n_first", 1, n1);
        chk("n_second", 32'(pair), n2);
        chk("n_mux", pair ? 2 : 1, seen.size());
        chk("mux1", 32'(exp_mux(s, a, b, 0)), 32'(seen[0]));
        if (pair)
            chk("mux2", 32'(exp_mux(s, a, b, 1)), 32'(seen[1]));
        chk("hold", 0, 32'(bad_hold));
        rd_reg(4'h3, v);
        chk("state_low", 32'({1'b0, s, b, a, 2'b00}), 32'(v[7:0]));
        if (pair)
            chk("state_res2", 32'(salt ^ {5'h00, exp_mux(s, a, b, 1)}), 32'(v[15:8]));
        rd_reg(4'h0, v);
        chk("status", {29'h0000_0000, abuse, pair, 1'b1}, v);
        chk("irq", 32'(abuse), 32'(irq));
        wr_reg(4'h0, 32'h0000_0007);
        rd_reg(4'h0, v);
        chk("cleared", 0, v);
        chk("irq_off", 0, 32'(irq));
        $display("test sel %0d abuse %0d done", s, abuse);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        pha = 1'b0;
        phb = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        salt = 8'h00;
        conv_data = 8'h00;
        prev_conv = 1'b0;
        bad_hold = 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("irq_rst", 0, 32'(irq));
        rd_reg(4'h2, r);
        chk("gain_rst", 0, r);
        rd_reg(4'h9, r);
        chk("unmapped", 0, r);
        wr_reg(4'h1, 32'h0000_0004);
        rd_reg(4'h1, r);
        chk("mask", 32'h0000_0004, r);
        for (int i = 0; i < 12; i++)
            run(codes[i], i[0] ^ i[2], i[0], i[1]);
        tally_and_finish();
    end
endmodule
